// file: verilog/sdiv_consts.svh
/*
  Constants of the divide-by-two-to-eight scaler: state codes, reset
  values and timing figures.
  Assumes inclusion by bare name, after any file header.
*/
`ifndef SDIV_CONSTS_SVH
`define SDIV_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and count rate
// ----------------------------------------------------------------
`define SDIV_CLK_HZ 20000000
`define SDIV_MAX_COUNT_HZ 10000
`define SDIV_MIN_COUNT_GAP_CYC (`SDIV_CLK_HZ / `SDIV_MAX_COUNT_HZ)

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SDIV_RATIO_W 4
`define SDIV_STATE_W 3
`define SDIV_STATE_RST 3'h0

// ----------------------------------------------------------------
// State codes named in the mode sequences (bits c, b, a)
// ----------------------------------------------------------------
`define SDIV_S000 3'h0
`define SDIV_S001 3'h1
`define SDIV_S010 3'h2
`define SDIV_S011 3'h3
`define SDIV_S100 3'h4
`define SDIV_S101 3'h5
`define SDIV_S110 3'h6
`define SDIV_S111 3'h7

`endif

// file: verilog/sdiv_pkg.sv
/*
  Types of the scaler: the ratio mode and the state records.
  Assumes sdiv_consts.svh is reachable on the include path.
*/
`default_nettype none
`include "sdiv_consts.svh"

package sdiv_pkg;

  // Selected division ratio
  typedef enum logic [2:0] {
    SDIV_DIV2, SDIV_DIV3, SDIV_DIV4, SDIV_DIV5, SDIV_DIV6, SDIV_DIV7, SDIV_DIV8
  } sdiv_mode_t;

  // Whole state of the scaler core
  typedef struct packed {
    sdiv_mode_t mode;
    logic [`SDIV_STATE_W-1:0] cnt;
    logic div;
  } sdiv_core_t;

  // Whole state of the edge detector
  typedef struct packed {
    logic prev;
  } sdiv_edge_t;

endpackage
`default_nettype wire

// file: verilog/sdiv_edge.sv
/*
  Rising-edge detector for the count input.
  Assumes the count input is synchronous to clock_in.
*/
`timescale 1ns/1ps
`default_nettype none

module sdiv_edge
  import sdiv_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Level in, step out
  input wire logic level_in,
  output logic rise_out
);

  sdiv_edge_t st_q;
  sdiv_edge_t st_d;

  // Next value: remember last level
  always_comb begin
    st_d = st_q;
    st_d.prev = level_in;
  end

  // Register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // One pulse per low-to-high change
  assign rise_out = level_in & ~st_q.prev;

endmodule
`default_nettype wire

// file: verilog/sdiv_scaler.sv
/*
  Scaler dividing a count pulse stream by 2, 3, 4, 5, 6, 7 or 8.
  Assumes count_in is synchronous to clock_in and rises no faster than
  the count rate limit; stages cascade by feeding div_out to count_in.
*/
// Notes on behaviour
// - Division ratios 2 through 8 are selectable on the ratio input.
// - Larger ratios come from cascading: div_out drives the next count_in.
// - Next state is prepared a step early; outputs are registered, no glitch.
// - Ratio 2: single toggling bit, changes on every count.
// - Ratio 3: three-stage ring with one active stage rotating per count.
// - Ratio 4: two-stage binary counter.
// - Ratio 5: five legal states; 101, 110, 111 are illegal.
// - Ratio 5: one count sends 101 to 010, 110 to 010, 111 to 000.
// - Ratio 6: three square waves at one sixth rate, 60 degrees apart.
// - Ratio 6: 010 counts to 101, which is forced at once to 111.
// - Ratio 7: illegal state 100 goes to 101 on next count.
// - Ratio 8: three-stage binary counter through all eight states.
`timescale 1ns/1ps
`default_nettype none

module sdiv_scaler
  import sdiv_pkg::*;
(
  // Clock and resets
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic srst_in,
  // Ratio select and count input
  input wire logic [`SDIV_RATIO_W-1:0] ratio_in,
  input wire logic count_in,
  // Divided outputs
  output logic div_out,
  output logic [`SDIV_STATE_W-1:0] phase_out,
  output logic [2:0] ratio_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Ratio number to mode; out-of-range numbers fall back to two
  function automatic sdiv_mode_t sdiv_mode_of(input logic [`SDIV_RATIO_W-1:0] r);
    case (r)
      4'h3: sdiv_mode_of = SDIV_DIV3;
      4'h4: sdiv_mode_of = SDIV_DIV4;
      4'h5: sdiv_mode_of = SDIV_DIV5;
      4'h6: sdiv_mode_of = SDIV_DIV6;
      4'h7: sdiv_mode_of = SDIV_DIV7;
      4'h8: sdiv_mode_of = SDIV_DIV8;
      default: sdiv_mode_of = SDIV_DIV2;
    endcase
  endfunction

  // State after one count step, per mode
  function automatic logic [2:0] sdiv_step(input sdiv_mode_t m, input logic [2:0] s);
    sdiv_step = s;
    case (m)
      SDIV_DIV2: begin
        sdiv_step = {2'h0, ~s[0]};
      end
      SDIV_DIV3: begin
        case (s)
          `SDIV_S001: sdiv_step = `SDIV_S010;
          `SDIV_S010: sdiv_step = `SDIV_S100;
          default: sdiv_step = `SDIV_S001;
        endcase
      end
      SDIV_DIV4: begin
        sdiv_step = {1'b0, s[1] ^ s[0], ~s[0]};
      end
      SDIV_DIV5: begin
        case (s)
          `SDIV_S100: sdiv_step = `SDIV_S000;
          `SDIV_S101: sdiv_step = `SDIV_S010;
          `SDIV_S110: sdiv_step = `SDIV_S010;
          `SDIV_S111: sdiv_step = `SDIV_S000;
          default: sdiv_step = s + 3'h1;
        endcase
      end
      SDIV_DIV6: begin
        sdiv_step = {s[1:0], ~s[2]};
      end
      SDIV_DIV7: begin
        case (s)
          `SDIV_S011: sdiv_step = `SDIV_S101;
          `SDIV_S100: sdiv_step = `SDIV_S101;
          default: sdiv_step = s + 3'h1;
        endcase
      end
      SDIV_DIV8: begin
        sdiv_step = s + 3'h1;
      end
      default: sdiv_step = `SDIV_STATE_RST;
    endcase
  endfunction

  // Bit of the state that carries the divided output
  function automatic logic sdiv_out_bit(input sdiv_mode_t m, input logic [2:0] s);
    case (m)
      SDIV_DIV2: sdiv_out_bit = s[0];
      SDIV_DIV4: sdiv_out_bit = s[1];
      default: sdiv_out_bit = s[2];
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Count edge detection
  // ----------------------------------------------------------------

  logic step;

  sdiv_edge u_edge (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .level_in(count_in),
    .rise_out(step)
  );

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------

  sdiv_core_t st_q;
  sdiv_core_t st_d;

  // Next state: reset, forced escape, or one count step
  always_comb begin
    st_d = st_q;
    if (srst_in) begin
      st_d.mode = sdiv_mode_of(ratio_in);
      st_d.cnt = `SDIV_STATE_RST;
    end else if (st_q.mode == SDIV_DIV6 && st_q.cnt == `SDIV_S101) begin
      st_d.cnt = `SDIV_S111;
    end else if (step) begin
      st_d.cnt = sdiv_step(st_q.mode, st_q.cnt);
    end
    st_d.div = sdiv_out_bit(st_d.mode, st_d.cnt);
  end

  // Register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign div_out = st_q.div;
  assign phase_out = st_q.cnt;
  assign ratio_out = st_q.mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  logic live;
  assign live = !srst_in;

  sequence s_div6_to_101;
    st_q.cnt == `SDIV_S101;
  endsequence

  sequence s_div6_fixed;
    st_q.cnt == `SDIV_S111;
  endsequence

  a_div2_toggle: assert property (
    live && step && st_q.mode == SDIV_DIV2 |=> st_q.cnt[0] != $past(st_q.cnt[0]) && div_out
      == st_q.cnt[0])
    else $error("divide-by-two bit did not toggle");

  a_ring_rotate: assert property (
    live && step && st_q.mode == SDIV_DIV3 && st_q.cnt == `SDIV_S001 |=>
      st_q.cnt == `SDIV_S010 ##0 (!step [*1]) or st_q.cnt == `SDIV_S010)
    else $error("ring did not rotate");

  a_div4_count: assert property (
    live && step && st_q.mode == SDIV_DIV4 |=>
      st_q.cnt[1:0] == $past(st_q.cnt[1:0]) + 2'h1 && st_q.cnt[2] == 1'b0)
    else $error("divide-by-four count wrong");

  a_div5_escape: assert property (
    live && step && st_q.mode == SDIV_DIV5 && st_q.cnt inside {`SDIV_S101, `SDIV_S110} |=>
      st_q.cnt == `SDIV_S010)
    else $error("divide-by-five illegal state not recovered");

  a_div5_wrap: assert property (
    live && step && st_q.mode == SDIV_DIV5 && st_q.cnt == `SDIV_S100 |=> st_q.cnt == `SDIV_S000)
    else $error("divide-by-five did not wrap after five");

  a_div6_pair: assert property (
    live && step && st_q.mode == SDIV_DIV6 && st_q.cnt == `SDIV_S010 ##1 live |->
      s_div6_to_101 ##1 s_div6_fixed)
    else $error("divide-by-six illegal pair not broken");

  a_div7_escape: assert property (
    live && step && st_q.mode == SDIV_DIV7 && st_q.cnt == `SDIV_S100 |=> st_q.cnt == `SDIV_S101)
    else $error("divide-by-seven illegal state not recovered");

  // Illegal codes cannot be reached from reset, so the step table is checked directly
  a_illegal_table: assert property (
    sdiv_step(SDIV_DIV5, `SDIV_S101) == `SDIV_S010
      && sdiv_step(SDIV_DIV5, `SDIV_S110) == `SDIV_S010
      && sdiv_step(SDIV_DIV5, `SDIV_S111) == `SDIV_S000
      && sdiv_step(SDIV_DIV6, `SDIV_S010) == `SDIV_S101
      && sdiv_step(SDIV_DIV7, `SDIV_S100) == `SDIV_S101)
    else $error("illegal state recovery table wrong");

  a_div8_count: assert property (
    live && step && st_q.mode == SDIV_DIV8 |=> st_q.cnt == $past(st_q.cnt) + 3'h1)
    else $error("divide-by-eight count wrong");

  a_hold_idle: assert property (
    live && !step && !(st_q.mode == SDIV_DIV6 && st_q.cnt == `SDIV_S101) |=> $stable(st_q.cnt))
    else $error("state moved without a count edge");

  a_reset_zero: assert property (
    srst_in |=> st_q.cnt == `SDIV_STATE_RST && st_q.mode == sdiv_mode_of($past(ratio_in)))
    else $error("synchronous reset did not clear state");

  a_mode_held: assert property (
    live |=> $stable(st_q.mode))
    else $error("ratio changed outside reset");

endmodule
`default_nettype wire

// file: verification/sdiv_count_src.sv
/*
  Upstream count source: one high pulse per request, then a quiet gap.
  Assumes the requester changes fire_in at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdiv_consts.svh"

module sdiv_count_src #(
  parameter int HIGH_CYC = 3,
  parameter int GAP_CYC = `SDIV_MIN_COUNT_GAP_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Request side
  input wire logic fire_in,
  output logic busy_out,
  // Count line to the scaler
  output logic count_out
);
  int cnt_q;

  // ----------------------------------------------------------------
  // Pulse then gap, so counts never come closer than GAP_CYC
  // ----------------------------------------------------------------
  always_ff @(negedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 0;
      count_out <= 1'b0;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      count_out <= (cnt_q - 1 > GAP_CYC - HIGH_CYC);
    end else if (fire_in) begin
      cnt_q <= GAP_CYC;
      count_out <= 1'b1;
    end
  end

  // Busy for the whole pulse and gap
  assign busy_out = (cnt_q != 0);
endmodule

`default_nettype wire

// file: verification/sdiv_scaler_tb.sv
/*
  Testbench of the scaler: walks every ratio and the reset behaviour.
  Assumes sdiv_pkg and the count source model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdiv_consts.svh"

module sdiv_scaler_tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic srst_in = 1'b0;
  logic [3:0] ratio_in = 4'h2;
  logic fire = 1'b0;
  logic busy;
  logic count_line;
  logic div_out;
  logic [2:0] phase_out;
  logic [2:0] ratio_out;
  logic [2:0] phase_nx;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  // Expected phase after counts 1..9, ratios 2..8
  logic [2:0] tbl [0:6][0:8] = '{
    '{3'h1, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0, 3'h1},
    '{3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h4, 3'h1, 3'h2, 3'h4},
    '{3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1},
    '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4},
    '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0, 3'h1, 3'h3, 3'h7},
    '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1, 3'h2},
    '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1}};

  // Clock, 50 ns period
  initial begin
    forever #25 clock_in = ~clock_in;
  end

  // Counts spaced at the rate limit
  sdiv_count_src #(.HIGH_CYC(3), .GAP_CYC(`SDIV_MIN_COUNT_GAP_CYC)) u_sdiv_count_src (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .fire_in(fire),
    .busy_out(busy), .count_out(count_line));

  sdiv_scaler u_sdiv_scaler (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .srst_in(srst_in),
    .ratio_in(ratio_in), .count_in(count_line), .div_out(div_out),
    .phase_out(phase_out), .ratio_out(ratio_out));

  // Second stage in cascade, counting the first stage's divided output
  sdiv_scaler u_sdiv_scaler_next (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .srst_in(srst_in),
    .ratio_in(ratio_in), .count_in(div_out), .div_out(),
    .phase_out(phase_nx), .ratio_out());

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Print the verdict and stop
  task automatic give_verdict;
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One count pulse: wait for an idle source, fire, wait until idle again
  task automatic pulse;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clock_in);
      n++;
    end
    @(negedge clock_in) fire <= 1'b1;
    @(negedge clock_in) fire <= 1'b0;
    @(negedge clock_in);
    while (busy !== 1'b0 && n < 6000) begin
      @(negedge clock_in);
      n++;
    end
  endtask

  // Synchronous reset loading a ratio number
  task automatic do_srst(input logic [3:0] r);
    @(negedge clock_in) ratio_in <= r;
    srst_in <= 1'b1;
    @(negedge clock_in) srst_in <= 1'b0;
  endtask

  // Walk one full cycle in one ratio; the second stage counts div_out rises
  task automatic walk_ratio(input int r);
    logic [2:0] e;
    logic d;
    logic d_last;
    int rises;
    d_last = 1'b0;
    rises = 0;
    do_srst(4'(r));
    check(8'(ratio_out), 8'(r - 2), "mode");
    check(8'(phase_out), 8'h00, "cleared");
    check(8'(phase_nx), 8'h00, "next cleared");
    for (int k = 0; k < r; k++) begin
      pulse();
      e = tbl[r - 2][k];
      d = (r == 2) ? e[0] : (r == 4) ? e[1] : e[2];
      check(8'(phase_out), 8'(e), "phase");
      check(8'(div_out), 8'(d), "div");
      if (d && !d_last) begin
        rises++;
      end
      d_last = d;
    end
    check(8'(phase_nx), 8'(tbl[r - 2][rises - 1]), "cascade");
  endtask

  // Count during synchronous reset is ignored
  task automatic srst_blocks;
    do_srst(4'h8);
    pulse();
    @(negedge clock_in) srst_in <= 1'b1;
    fire <= 1'b1;
    @(negedge clock_in) fire <= 1'b0;
    repeat (8) @(negedge clock_in);
    srst_in <= 1'b0;
    check(8'(phase_out), 8'h00, "srst count");
    pulse();
    check(8'(phase_out), 8'h01, "after srst");
  endtask

  // Ratio change without reset has no effect; bad number gives two
  task automatic ratio_hold;
    do_srst(4'h7);
    @(negedge clock_in) ratio_in <= 4'h3;
    repeat (4) pulse();
    check(8'(phase_out), 8'h05, "held seven");
    check(8'(ratio_out), 8'h05, "held mode");
    do_srst(4'hf);
    check(8'(ratio_out), 8'h00, "bad ratio");
    repeat (3) pulse();
    check(8'(phase_out), 8'h01, "bad ratio walk");
  endtask

  // Hang guard
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 95000) begin
      failures++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(negedge clock_in);
    rst_n_in = 1'b1;
    check(8'(phase_out), 8'h00, "reset");
    for (int r = 2; r <= 8; r++) begin
      walk_ratio(r);
    end
    srst_blocks();
    ratio_hold();
    give_verdict();
  end
endmodule

`default_nettype wire
